// ### common/dfrp_defines.vh
`ifndef DFRP_DEFINES_VH
`define DFRP_DEFINES_VH

// ----------------------------------------------------------------------------
// Geometry of one field port
// ----------------------------------------------------------------------------
`define DFRP_DW 8
`define DFRP_AW 19
`define DFRP_DEPTH 19'h4_0046
`define DFRP_LAST_ADDR 19'h4_0045
`define DFRP_FIRST_ADDR 19'h0_0000

// ----------------------------------------------------------------------------
// Read lag limits, in addresses
// ----------------------------------------------------------------------------
`define DFRP_OLD_LAG 19'h0_0046
`define DFRP_NEW_LAG 19'h0_0258

// ----------------------------------------------------------------------------
// Old-data holding ring and write-side FIFO
// ----------------------------------------------------------------------------
`define DFRP_RING_LAST 7'h45
`define DFRP_RING_FIRST 7'h00
`define DFRP_FIFO_DEPTH 8
`define DFRP_FIFO_AW 3
`define DFRP_FIFO_W 9

// ----------------------------------------------------------------------------
// Register offsets, fields and reset values
// ----------------------------------------------------------------------------
`define DFRP_RA_CTRL 8'h00
`define DFRP_RA_STATUS 8'h04
`define DFRP_RA_READ_PTR 8'h08
`define DFRP_RA_WRITE_PTR 8'h0C
`define DFRP_RA_LAG 8'h10
`define DFRP_CTRL_RESET 32'h0000_0001
`define DFRP_CTRL_EN_BIT 0
`define DFRP_ST_CASCADE_BIT 0
`define DFRP_ST_POLARITY_BIT 1
`define DFRP_ST_BOOST_BIT 2
`define DFRP_ST_FIFO_BUSY_BIT 3
`define DFRP_ST_OLD_BIT 4
`define DFRP_ST_NEW_BIT 5
`define DFRP_ST_OE_BIT 6

`endif

// ### src/dfrp_fifo.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Synchronous FIFO; DEPTH must be a power of two matching AW.
// ----------------------------------------------------------------------------
module dfrp_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire srst,
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output reg in_ready,
	output wire out_valid,
	output wire [WIDTH-1:0] out_data,
	input wire out_ready
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	reg [AW:0] count_next;
	wire push;
	wire pop;

	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = store[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @* begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + 1'b1;
		else if (pop & ~push)
			count_next = count_reg - 1'b1;
	end

	// Ready is registered so the top-level port comes from a flip-flop.
	always @(posedge clk) begin
		if (srst) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			// DEPTH is 2**AW, so the top count bit is set exactly when full.
			in_ready <= ~count_next[AW];
		end
	end

	always @(posedge clk) begin
		if (push)
			store[wr_ptr_reg] <= in_data;
	end
endmodule // dfrp_fifo

`default_nettype wire

// ### src/dfrp_field_mem.v
`timescale 1ns/100ps
`default_nettype none
`include "dfrp_defines.vh"

// ----------------------------------------------------------------------------
// Single-port field store with a registered read.
// ----------------------------------------------------------------------------
module dfrp_field_mem (
	input wire clk,
	input wire wr_en,
	input wire [`DFRP_AW-1:0] wr_addr,
	input wire [`DFRP_DW-1:0] wr_data,
	input wire rd_en,
	input wire [`DFRP_AW-1:0] rd_addr,
	output reg [`DFRP_DW-1:0] rd_data
);
	reg [`DFRP_DW-1:0] cells [0:`DFRP_LAST_ADDR];

	// The owner never asserts both enables in one cycle.
	always @(posedge clk) begin
		if (wr_en)
			cells[wr_addr] <= wr_data;
		else if (rd_en)
			rd_data <= cells[rd_addr];
	end
endmodule // dfrp_field_mem

`default_nettype wire

// ### src/dfrp_read_port.v
`timescale 1ns/100ps
`default_nettype none
`include "dfrp_defines.vh"

// Notes on behaviour
// - Read reset edge sets pointer to zero.
// - Gates ignored during the read reset cycle.
// - Output gate active drives data outputs.
// - Output gate never stops pointer advance.
// - Cascade strap high selects cascade mode.
// - Non-cascade acts in the sampled cycle.
// - Cascade acts one read cycle later.
// - Polarity strap high makes controls active low.
// - Lag above 600 returns new data.
// - Lag below 70 returns old data.
// - Middle lags undetermined, writes still complete.
// - Read gate active advances the pointer.
// - Read gate inactive holds the pointer.

module dfrp_read_port (
	input wire CLK,
	input wire SRST,
	input wire SERIAL_READ_CLK,
	input wire PORT_B_READ_RESET_STROBE,
	input wire PORT_B_READ_GATE,
	input wire PORT_B_OUTPUT_GATE,
	input wire CASCADE_SELECT_STRAP,
	input wire CONTROL_POLARITY_STRAP,
	input wire OUTPUT_BOOST_STRAP,
	input wire WR_VALID,
	input wire [`DFRP_DW-1:0] WR_DATA,
	input wire WRITE_POINTER_RESET_STROBE,
	output wire WR_READY,
	output reg [`DFRP_DW-1:0] DOUT,
	output reg DOUT_OE,
	input wire [7:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [31:0] REG_RDATA
);
	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Next address, wrapping after the last location of the field.
	function [`DFRP_AW-1:0] ptr_inc;
		input [`DFRP_AW-1:0] p;
		begin
			if (p == `DFRP_LAST_ADDR)
				ptr_inc = `DFRP_FIRST_ADDR;
			else
				ptr_inc = p + 1'b1;
		end
	endfunction

	// Distance from behind up to ahead, taken around the field's ring.
	function [`DFRP_AW-1:0] ptr_dist;
		input [`DFRP_AW-1:0] ahead;
		input [`DFRP_AW-1:0] behind;
		begin
			if (ahead >= behind)
				ptr_dist = ahead - behind;
			else
				ptr_dist = ahead + (`DFRP_DEPTH - behind);
		end
	endfunction

	// A high polarity strap turns the three read control pins active low; the write pointer reset strobe stays active high.
	function ctl_active;
		input pin;
		input pol;
		begin
			ctl_active = pin ^ pol;
		end
	endfunction

	// ------------------------------------------------------------------------
	// Strap capture and control decode
	// ------------------------------------------------------------------------
	reg cascade_reg;
	reg polarity_reg;
	reg boost_reg;
	reg rck_prev_reg;
	wire rck_edge;
	wire cur_rst;
	wire cur_gate;
	wire cur_oe;

	// Straps are caught while reset is held and frozen afterwards, because
	// changing them during operation leaves stored data meaningless.
	always @(posedge CLK) begin
		if (SRST) begin
			cascade_reg <= CASCADE_SELECT_STRAP;
			polarity_reg <= CONTROL_POLARITY_STRAP;
			boost_reg <= OUTPUT_BOOST_STRAP;
		end
	end

	// The detector follows the pin through reset as well, so a read clock
	// left high across a reset is not taken for a fresh rising edge.
	always @(posedge CLK) begin
		rck_prev_reg <= SERIAL_READ_CLK;
	end

	assign rck_edge = SERIAL_READ_CLK & ~rck_prev_reg;
	assign cur_rst = ctl_active(PORT_B_READ_RESET_STROBE, polarity_reg);
	assign cur_gate = ctl_active(PORT_B_READ_GATE, polarity_reg);
	assign cur_oe = ctl_active(PORT_B_OUTPUT_GATE, polarity_reg);

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	reg [31:0] ctrl_reg;
	wire port_en;
	wire fifo_busy;
	reg [`DFRP_AW-1:0] rptr_reg;
	reg [`DFRP_AW-1:0] wptr_reg;
	reg [`DFRP_AW-1:0] lag_reg;
	reg oe_stage_reg;
	reg [31:0] rdata_next;
	wire [31:0] status_word;
	wire lag_is_old;
	wire lag_is_new;

	assign port_en = ctrl_reg[`DFRP_CTRL_EN_BIT];

	always @(posedge CLK) begin
		if (SRST)
			ctrl_reg <= `DFRP_CTRL_RESET;
		else if (REG_WR && REG_ADDR == `DFRP_RA_CTRL)
			ctrl_reg <= {31'h0000_0000, REG_WDATA[`DFRP_CTRL_EN_BIT]};
	end

	// The lag is registered, so both flags trail the pointers by one clock;
	// they are a guide for software, not a cycle-exact window.
	assign lag_is_old = (lag_reg < `DFRP_OLD_LAG);
	assign lag_is_new = (lag_reg > `DFRP_NEW_LAG);

	assign status_word = {25'h000_0000,
		DOUT_OE,
		lag_is_new,
		lag_is_old,
		fifo_busy,
		boost_reg,
		polarity_reg,
		cascade_reg};

	always @* begin
		case (REG_ADDR)
		`DFRP_RA_CTRL: rdata_next = ctrl_reg;
		`DFRP_RA_STATUS: rdata_next = status_word;
		`DFRP_RA_READ_PTR: rdata_next = {13'h0000, rptr_reg};
		`DFRP_RA_WRITE_PTR: rdata_next = {13'h0000, wptr_reg};
		`DFRP_RA_LAG: rdata_next = {13'h0000, lag_reg};
		default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always @(posedge CLK) begin
		if (SRST)
			REG_RDATA <= 32'h0000_0000;
		else if (REG_RD)
			REG_RDATA <= rdata_next;
		else
			REG_RDATA <= 32'h0000_0000;
	end

	// ------------------------------------------------------------------------
	// Read control: cascade stage and action selection
	// ------------------------------------------------------------------------
	reg pend_rst_reg;
	reg pend_gate_reg;
	reg pend_oe_reg;
	wire act_edge;
	wire sel_rst;
	wire sel_gate;
	wire sel_oe;
	wire mem_rd;
	reg rd_pending_reg;

	// A read edge while the port is disabled is dropped whole: neither the
	// pointer nor the cascade stage moves.
	assign act_edge = rck_edge & port_en;
	// Non-cascade acts on the controls sampled at this edge, cascade on
	// those sampled one read cycle earlier.
	assign sel_rst = cascade_reg ? pend_rst_reg : cur_rst;
	assign sel_gate = cascade_reg ? pend_gate_reg : cur_gate;
	assign sel_oe = cascade_reg ? pend_oe_reg : cur_oe;

	// The stage holds effective levels, so a polarity change under reset
	// cannot leave a stale active strobe waiting in it.
	always @(posedge CLK) begin
		if (SRST) begin
			pend_rst_reg <= 1'b0;
			pend_gate_reg <= 1'b0;
			pend_oe_reg <= 1'b0;
		end else if (act_edge) begin
			pend_rst_reg <= cur_rst;
			pend_gate_reg <= cur_gate;
			pend_oe_reg <= cur_oe;
		end
	end

	// Reset takes priority; gate levels are not looked at in that cycle.
	assign mem_rd = act_edge & ~sel_rst & sel_gate;

	// A reset edge leaves the enable stage alone, so the data pins keep
	// their last drive state through that read cycle.
	always @(posedge CLK) begin
		if (SRST) begin
			rptr_reg <= `DFRP_FIRST_ADDR;
			oe_stage_reg <= 1'b0;
		end else if (act_edge) begin
			if (sel_rst) begin
				rptr_reg <= `DFRP_FIRST_ADDR;
			end else begin
				oe_stage_reg <= sel_oe;
				if (sel_gate)
					rptr_reg <= ptr_inc(rptr_reg);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------------------
	wire [`DFRP_DW-1:0] mem_rdata;

	always @(posedge CLK) begin
		if (SRST)
			rd_pending_reg <= 1'b0;
		else
			rd_pending_reg <= mem_rd;
	end

	// Data and enable land together, two clocks after the read edge.
	// The byte register loads on every advance whatever the output gate;
	// the gate only decides whether the pins are driven.
	always @(posedge CLK) begin
		if (SRST) begin
			DOUT <= {`DFRP_DW{1'b0}};
			DOUT_OE <= 1'b0;
		end else begin
			if (rd_pending_reg)
				DOUT <= mem_rdata;
			DOUT_OE <= oe_stage_reg;
		end
	end

	// ------------------------------------------------------------------------
	// Write stream: FIFO, old-data ring, field store
	// ------------------------------------------------------------------------
	wire fifo_valid;
	wire [`DFRP_FIFO_W-1:0] fifo_data;
	wire fifo_take;
	wire w_restart;
	wire [`DFRP_AW-1:0] w_addr;
	reg [`DFRP_AW+`DFRP_DW-1:0] ring [0:`DFRP_RING_LAST];
	reg [`DFRP_RING_LAST:0] ring_valid_reg;
	reg [6:0] ring_idx_reg;
	wire [`DFRP_AW+`DFRP_DW-1:0] ring_out;
	wire commit;

	assign fifo_busy = fifo_valid;

	// The store has one port, so a read access stalls the write drain and
	// the back-pressure reaches the writer through WR_READY.
	assign fifo_take = fifo_valid & ~mem_rd;

	dfrp_fifo #(
		.WIDTH(`DFRP_FIFO_W),
		.DEPTH(`DFRP_FIFO_DEPTH),
		.AW(`DFRP_FIFO_AW)
	) u_fifo (
		.clk(CLK),
		.srst(SRST),
		.in_valid(WR_VALID),
		.in_data({WRITE_POINTER_RESET_STROBE, WR_DATA}),
		.in_ready(WR_READY),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(~mem_rd)
	);

	assign w_restart = fifo_data[`DFRP_FIFO_W-1];
	assign w_addr = w_restart ? `DFRP_FIRST_ADDR : wptr_reg;
	assign ring_out = ring[ring_idx_reg];
	assign commit = fifo_take & ring_valid_reg[ring_idx_reg];

	always @(posedge CLK) begin
		if (SRST)
			wptr_reg <= `DFRP_FIRST_ADDR;
		else if (fifo_take)
			wptr_reg <= ptr_inc(w_addr);
	end

	// Each written byte waits in the ring for the next 70 writes before it
	// reaches the store, so a read that trails by fewer still sees the
	// previous field. Bytes still in the ring at the end of a field are
	// flushed only by later writes.
	always @(posedge CLK) begin
		if (fifo_take)
			ring[ring_idx_reg] <= {w_addr, fifo_data[`DFRP_DW-1:0]};
	end

	// Valid bits stop stale ring entries from reaching the store after reset.
	always @(posedge CLK) begin
		if (SRST) begin
			ring_idx_reg <= `DFRP_RING_FIRST;
			ring_valid_reg <= {(`DFRP_RING_LAST+1){1'b0}};
		end else if (fifo_take) begin
			ring_valid_reg[ring_idx_reg] <= 1'b1;
			if (ring_idx_reg == `DFRP_RING_LAST)
				ring_idx_reg <= `DFRP_RING_FIRST;
			else
				ring_idx_reg <= ring_idx_reg + 1'b1;
		end
	end

	// Writes commit whatever the read lag; middle lags only blur reads.
	dfrp_field_mem u_mem (
		.clk(CLK),
		.wr_en(commit),
		.wr_addr(ring_out[`DFRP_AW+`DFRP_DW-1:`DFRP_DW]),
		.wr_data(ring_out[`DFRP_DW-1:0]),
		.rd_en(mem_rd),
		.rd_addr(rptr_reg),
		.rd_data(mem_rdata)
	);

	always @(posedge CLK) begin
		if (SRST)
			lag_reg <= `DFRP_FIRST_ADDR;
		else
			lag_reg <= ptr_dist(wptr_reg, rptr_reg);
	end
endmodule // dfrp_read_port

`default_nettype wire

// ### tb/dfrp_video_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Video host driving the read side
// ----------------------------------------
module dfrp_video_host (
	input wire logic clk,
	input wire logic pol,
	output logic rclk,
	output logic rst_pin,
	output logic gate_pin,
	output logic oe_pin
);
	initial begin
		rclk = 1'b0;
		rst_pin = 1'b0;
		gate_pin = 1'b0;
		oe_pin = 1'b0;
	end
	// Controls are held over both phases so the read edge never sees them move.
	task automatic cyc(input logic rst, input logic gate, input logic oe);
		begin
			rst_pin <= rst ^ pol;
			gate_pin <= gate ^ pol;
			oe_pin <= oe ^ pol;
			rclk <= 1'b0;
			@(posedge clk);
			rclk <= 1'b1;
			@(posedge clk);
		end
	endtask
endmodule // dfrp_video_host
`default_nettype wire

// ### tb/dfrp_read_port_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Read port checker
// ----------------------------------------
module dfrp_read_port_chk (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SERIAL_READ_CLK,
	input wire logic PORT_B_READ_RESET_STROBE,
	input wire logic PORT_B_READ_GATE,
	input wire logic PORT_B_OUTPUT_GATE,
	input wire logic CASCADE_SELECT_STRAP,
	input wire logic CONTROL_POLARITY_STRAP,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic [7:0] DOUT,
	input wire logic DOUT_OE
);
	logic rclk_q, en_q, casc_q, pol_q, prv_rst, prv_oe;
	wire rd_edge = SERIAL_READ_CLK & ~rclk_q;
	wire go = rd_edge & en_q;
	wire rst_act = PORT_B_READ_RESET_STROBE ^ pol_q;
	wire oe_act = PORT_B_OUTPUT_GATE ^ pol_q;
	wire gate_act = PORT_B_READ_GATE ^ pol_q;
	wire prv_rst_act = prv_rst;
	wire prv_oe_act = prv_oe;
	always @(posedge CLK) begin
		rclk_q <= SERIAL_READ_CLK;
		if (SRST) begin
			en_q <= 1'b1;
			casc_q <= CASCADE_SELECT_STRAP;
			pol_q <= CONTROL_POLARITY_STRAP;
			prv_rst <= 1'b0;
			prv_oe <= 1'b0;
		end else begin
			if (REG_WR && REG_ADDR == 8'h00)
				en_q <= REG_WDATA[0];
			if (go) begin
				prv_rst <= rst_act;
				prv_oe <= oe_act;
			end
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
		else $error("read data not idle");
	AST_DOUT_CAUSE: assert property ($changed(DOUT) |-> $past(go, 2))
		else $error("data moved without read edge");
	AST_OE_CAUSE: assert property ($changed(DOUT_OE) |-> $past(go, 2))
		else $error("enable moved without read edge");
	AST_OE_FOLLOWS: assert property (go && !casc_q && !rst_act
		|-> ##2 DOUT_OE == $past(oe_act, 2)) else $error("enable wrong");
	AST_RESET_KEEPS: assert property (go && !casc_q && rst_act
		|-> ##2 $stable(DOUT_OE) && $stable(DOUT)) else $error("reset moved output");
	AST_GATE_HOLD: assert property (go && !casc_q && !rst_act && !gate_act
		|-> ##2 $stable(DOUT)) else $error("data moved with gate off");
	AST_CASC_OE: assert property (go && casc_q && !prv_rst_act
		|-> ##2 DOUT_OE == $past(prv_oe_act, 2)) else $error("cascade enable wrong");
	AST_CASC_RESET: assert property (go && casc_q && prv_rst_act
		|-> ##2 $stable(DOUT_OE)) else $error("cascade reset moved enable");
	AST_DISABLED: assert property (rd_edge && !en_q
		|-> ##2 $stable(DOUT) && $stable(DOUT_OE)) else $error("disabled edge acted");
endmodule // dfrp_read_port_chk
bind dfrp_read_port dfrp_read_port_chk u_chk (
	.CLK(CLK), .SRST(SRST), .SERIAL_READ_CLK(SERIAL_READ_CLK),
	.PORT_B_READ_RESET_STROBE(PORT_B_READ_RESET_STROBE),
	.PORT_B_READ_GATE(PORT_B_READ_GATE), .PORT_B_OUTPUT_GATE(PORT_B_OUTPUT_GATE),
	.CASCADE_SELECT_STRAP(CASCADE_SELECT_STRAP),
	.CONTROL_POLARITY_STRAP(CONTROL_POLARITY_STRAP), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .DOUT(DOUT), .DOUT_OE(DOUT_OE)
);
`default_nettype wire

// ### tb/test_dual_field_fifo_read_port_modes.sv
`timescale 1ns/100ps
`default_nettype none
`include "dfrp_defines.vh"
// ----------------------------------------
// Read port bench
// ----------------------------------------
module test_dual_field_fifo_read_port_modes;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic casc = 1'b0;
	logic pol = 1'b0;
	logic wr_valid = 1'b0;
	logic wr_restart = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	wire rclk, rst_pin, gate_pin, oe_pin, wr_ready, dout_oe;
	wire [7:0] dout;
	wire [31:0] reg_rdata;
	int fails = 0;
	int compares = 0;
	int i;
	always #12.5 CLK = ~CLK;
	dfrp_video_host u_host (.clk(CLK), .pol(pol), .rclk(rclk), .rst_pin(rst_pin),
		.gate_pin(gate_pin), .oe_pin(oe_pin));
	dfrp_read_port u_dut (
		.CLK(CLK), .SRST(SRST), .SERIAL_READ_CLK(rclk),
		.PORT_B_READ_RESET_STROBE(rst_pin), .PORT_B_READ_GATE(gate_pin),
		.PORT_B_OUTPUT_GATE(oe_pin), .CASCADE_SELECT_STRAP(casc),
		.CONTROL_POLARITY_STRAP(pol), .OUTPUT_BOOST_STRAP(1'b1),
		.WR_VALID(wr_valid), .WR_DATA(wr_data), .WRITE_POINTER_RESET_STROBE(wr_restart),
		.WR_READY(wr_ready), .DOUT(dout), .DOUT_OE(dout_oe), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
	);
	task automatic print_verdict;
		begin
			$display("fails %0d compares %0d", fails, compares);
			if (fails == 0 && compares > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			compares++;
			if (got !== exp) begin
				fails++;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Straps move only while reset is held, since the block samples them then.
	task automatic do_reset(input logic c, input logic p);
		begin
			casc <= c;
			pol <= p;
			SRST <= 1'b1;
			repeat (8) @(posedge CLK);
			SRST <= 1'b0;
			@(posedge CLK);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge CLK);
			reg_wr <= 1'b0;
			@(posedge CLK);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge CLK);
			reg_rd <= 1'b0;
			@(posedge CLK);
			chk(reg_rdata, exp);
		end
	endtask
	// One field with the restart flag on its first byte, then time to drain.
	task automatic fill(input int cnt, input logic [7:0] k);
		int j, n;
		begin
			for (j = 0; j < cnt; j++) begin
				wr_valid <= 1'b1;
				wr_data <= j[7:0] ^ k;
				wr_restart <= (j == 0);
				n = 0;
				do begin
					@(posedge CLK);
					n++;
				end while (wr_ready !== 1'b1 && n < 50);
				if (wr_ready !== 1'b1) begin
					chk({31'h0, wr_ready}, 32'h0000_0001);
					print_verdict();
				end
			end
			wr_valid <= 1'b0;
			wr_restart <= 1'b0;
			repeat (16) @(posedge CLK);
		end
	endtask
	task automatic look(input logic [7:0] d, input logic oe, input logic cd);
		begin
			repeat (3) @(posedge CLK);
			if (cd)
				chk({24'h0, dout}, {24'h0, d});
			chk({31'h0, dout_oe}, {31'h0, oe});
		end
	endtask
	initial begin
		do_reset(1'b0, 1'b0);
		rd(`DFRP_RA_CTRL, 32'h0000_0001);
		rd(`DFRP_RA_STATUS, 32'h0000_0014);
		rd(8'h14, 32'h0000_0000);
		fill(700, 8'h5A);
		rd(`DFRP_RA_STATUS, 32'h0000_0024);
		rd(`DFRP_RA_LAG, 32'h0000_02BC);
		rd(`DFRP_RA_WRITE_PTR, 32'h0000_02BC);
		u_host.cyc(1'b0, 1'b1, 1'b1);
		look(8'h5A, 1'b1, 1'b1);
		u_host.cyc(1'b0, 1'b1, 1'b0);
		look(8'h00, 1'b0, 1'b0);
		u_host.cyc(1'b0, 1'b0, 1'b1);
		rd(`DFRP_RA_READ_PTR, 32'h0000_0002);
		u_host.cyc(1'b0, 1'b1, 1'b1);
		look(8'h58, 1'b1, 1'b1);
		wr(`DFRP_RA_CTRL, 32'h0000_0000);
		u_host.cyc(1'b0, 1'b1, 1'b1);
		rd(`DFRP_RA_READ_PTR, 32'h0000_0003);
		wr(`DFRP_RA_CTRL, 32'h0000_0001);
		u_host.cyc(1'b1, 1'b0, 1'b0);
		look(8'h58, 1'b1, 1'b1);
		rd(`DFRP_RA_READ_PTR, 32'h0000_0000);
		for (i = 0; i < 5; i++) begin
			u_host.cyc(1'b0, 1'b1, 1'b1);
			look(i[7:0] ^ 8'h5A, 1'b1, 1'b1);
		end
		fill(20, 8'hC3);
		u_host.cyc(1'b1, 1'b1, 1'b1);
		u_host.cyc(1'b0, 1'b1, 1'b1);
		look(8'h5A, 1'b1, 1'b1);
		do_reset(1'b1, 1'b1);
		rd(`DFRP_RA_STATUS, 32'h0000_0017);
		fill(700, 8'hA5);
		u_host.cyc(1'b1, 1'b0, 1'b0);
		u_host.cyc(1'b0, 1'b1, 1'b1);
		look(8'h00, 1'b0, 1'b1);
		u_host.cyc(1'b0, 1'b1, 1'b1);
		look(8'hA5, 1'b1, 1'b1);
		u_host.cyc(1'b0, 1'b0, 1'b0);
		look(8'hA4, 1'b1, 1'b1);
		print_verdict();
	end
endmodule // test_dual_field_fifo_read_port_modes
`default_nettype wire
